// >>> pkg/regbank_pkg.sv
// package: mode codes, status word layout, reset values, bank mapping
// assumes: one core clock; decoder supplies logical register indices
package regbank_pkg;

  typedef logic [31:0] word_type;
  typedef logic [4:0] mode_type;
  typedef logic [3:0] index_type;
  typedef logic [4:0] slot_type;
  typedef logic [2:0] class_type;

  // ----------------------------------------
  // processor mode encodings
  // ----------------------------------------
  localparam mode_type MODE_USR = 5'h10;
  localparam mode_type MODE_FAST = 5'h11;
  localparam mode_type MODE_IRQ = 5'h12;
  localparam mode_type MODE_SUPER = 5'h13;
  localparam mode_type MODE_ABT = 5'h14;
  localparam mode_type MODE_UND = 5'h15;
  localparam mode_type MODE_SYS = 5'h16;

  // ----------------------------------------
  // status word fields
  // ----------------------------------------
  localparam int FLAG_LSB = 28;
  localparam int IRQ_OFF_BIT = 7;
  localparam int FAST_OFF_BIT = 6;
  localparam int STATE_BIT = 5;
  localparam int MODE_LSB = 0;
  localparam word_type STATUS_MASK = 32'hF00000FF;
  localparam word_type STATUS_RST = 32'h000000D3;

  // ----------------------------------------
  // register file geometry
  // ----------------------------------------
  localparam int NUM_PHYS = 31;
  localparam int NUM_SAVED = 5;
  localparam int NUM_CLASS = 5;
  localparam slot_type PC_SLOT = 5'h0F;
  localparam slot_type FAST_LOW_SLOT = 5'h10;
  localparam index_type IDX_SP = 4'hD;
  localparam index_type IDX_LINK = 4'hE;
  localparam index_type IDX_PC = 4'hF;

  // ----------------------------------------
  // exception classes, index is priority (0 highest)
  // ----------------------------------------
  localparam class_type CLS_ABT = 3'h0;
  localparam class_type CLS_FAST = 3'h1;
  localparam class_type CLS_IRQ = 3'h2;
  localparam class_type CLS_UND = 3'h3;
  localparam class_type CLS_TRAP = 3'h4;
  localparam word_type VEC_BASE = 32'h00000000;

  // ----------------------------------------
  // condition field position and codes
  // ----------------------------------------
  localparam int COND_LSB = 28;
  localparam logic [3:0] COND_AL = 4'hE;

  function automatic mode_type exc_mode(input class_type c);
    unique case (c)
      CLS_ABT: exc_mode = MODE_ABT;
      CLS_FAST: exc_mode = MODE_FAST;
      CLS_IRQ: exc_mode = MODE_IRQ;
      CLS_UND: exc_mode = MODE_UND;
      default: exc_mode = MODE_SUPER;
    endcase
  endfunction

  function automatic logic has_saved(input mode_type m);
    has_saved = (m == MODE_FAST) || (m == MODE_IRQ) || (m == MODE_SUPER) ||
                (m == MODE_ABT) || (m == MODE_UND);
  endfunction

  function automatic logic [2:0] saved_slot(input mode_type m);
    unique case (m)
      MODE_FAST: saved_slot = 3'h0;
      MODE_IRQ: saved_slot = 3'h1;
      MODE_SUPER: saved_slot = 3'h2;
      MODE_ABT: saved_slot = 3'h3;
      default: saved_slot = 3'h4;
    endcase
  endfunction

  // logical index to physical slot for a mode
  function automatic slot_type phys_index(input mode_type m, input index_type i);
    slot_type base;
    base = 5'h00;
    if (i < 4'h8 || i == IDX_PC) begin
      phys_index = {1'b0, i};
    end else if (m == MODE_FAST) begin
      phys_index = FAST_LOW_SLOT + {1'b0, i} - 5'h08;
    end else if (i > 4'hC) begin
      unique case (m)
        MODE_IRQ: base = 5'h17;
        MODE_SUPER: base = 5'h19;
        MODE_ABT: base = 5'h1B;
        MODE_UND: base = 5'h1D;
        default: base = 5'h0D;
      endcase
      phys_index = base + {4'h0, i == IDX_LINK};
    end else begin
      phys_index = {1'b0, i};
    end
  endfunction

endpackage

// >>> pkg/exc_if.sv
// interface: exception requests and grant between core and arbiter
// assumes: requests are levels on the core clock
`timescale 1ns/1ps
interface exc_if;
  logic [4:0] req;
  logic fast_off;
  logic irq_off;
  logic grant;
  logic [2:0] cls;
  modport arb (input req, input fast_off, input irq_off, output grant, output cls);
  modport core (output req, output fast_off, output irq_off, input grant, input cls);
endinterface

// >>> design/exc_arbiter.sv
// module: fixed priority pick among pending exception requests
// assumes: request bit n is exception class n
`timescale 1ns/1ps
module exc_arbiter (
  exc_if.arb ex
);
  import regbank_pkg::*;

  logic [4:0] live;

  always_comb begin
    live = ex.req;
    live[CLS_FAST] = ex.req[CLS_FAST] & ~ex.fast_off;
    live[CLS_IRQ] = ex.req[CLS_IRQ] & ~ex.irq_off;
    ex.grant = |live;
    ex.cls = CLS_TRAP;
    // lowest index wins, see RQ13, see RQ17
    for (int k = NUM_CLASS - 1; k >= 0; k--) begin
      if (live[k]) begin
        ex.cls = 3'(k);
      end
    end
  end
endmodule

// >>> design/cond_check.sv
// module: evaluates an instruction condition field against the flags
// assumes: flags ordered negative, zero, carry, overflow from msb
`timescale 1ns/1ps
module cond_check (
  input wire logic [3:0] cond,
  input wire logic [3:0] flags,
  output logic pass
);
  import regbank_pkg::*;

  logic n, z, c, v;

  always_comb begin
    {n, z, c, v} = flags;
    // see RQ14
    unique case (cond)
      4'h0: pass = z;
      4'h1: pass = ~z;
      4'h2: pass = c;
      4'h3: pass = ~c;
      4'h4: pass = n;
      4'h5: pass = ~n;
      4'h6: pass = v;
      4'h7: pass = ~v;
      4'h8: pass = c & ~z;
      4'h9: pass = ~c | z;
      4'hA: pass = n == v;
      4'hB: pass = n != v;
      4'hC: pass = ~z & (n == v);
      4'hD: pass = z | (n != v);
      COND_AL: pass = 1'b1;
      4'hF: pass = 1'b0;
    endcase
  end
endmodule

// >>> design/regbank_core.sv
// module: banked register file, status word and exception entry/return
// assumes: decoder drives one request per cycle; core clock 10 MHz
// Notes on behaviour
// RQ1 - indices 0..7 hit one shared physical register in every mode
// RQ2 - indices 8..14 pick their physical register by current mode
// RQ3 - each exception mode has private copies of registers 13 and 14
// RQ4 - entry writes the return address into the new mode's register 14
// RQ5 - each exception mode has its own stack pointer register 13
// RQ6 - fast interrupt mode also swaps in private registers 8..12
// RQ7 - system mode uses user registers and may still take exceptions
// RQ8 - status word holds four flags, two masks, state bit, mode field
// RQ9 - each exception mode saves the status word seen just before entry
// RQ10 - five exception classes, each entering its own privileged mode
// RQ11 - entry saves state into banked register 14 and saved status
// RQ12 - return copies saved status to status and register 14 to pc
// RQ13 - simultaneous exception requests are resolved cleanly
// RQ14 - instructions run only when their 4-bit top condition holds
// RQ15 - 31 physical registers, 16 visible at once
// RQ16 - index 15 is the shared program counter
// RQ17 - fixed priority abort, fast, normal, undefined, trap; chosen modes
`timescale 1ns/1ps
module regbank_core (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire regbank_pkg::index_type reg_addr,
  input wire regbank_pkg::word_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output regbank_pkg::word_type reg_rdata,
  // status updates
  input wire logic flags_wr,
  input wire logic [3:0] flags_in,
  input wire logic status_wr,
  input wire regbank_pkg::word_type status_wdata,
  // exceptions
  input wire logic [4:0] exc_req,
  input wire regbank_pkg::word_type ret_addr,
  input wire logic exc_return,
  output logic exc_taken,
  output regbank_pkg::class_type exc_class,
  // condition check
  input wire regbank_pkg::word_type instr,
  output logic cond_pass,
  // state view
  output regbank_pkg::word_type status_word,
  output regbank_pkg::word_type pc,
  output regbank_pkg::mode_type cur_mode
);
  import regbank_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  word_type regs_q [NUM_PHYS];
  word_type regs_d [NUM_PHYS];
  word_type saved_q [NUM_SAVED];
  word_type saved_d [NUM_SAVED];
  word_type status_q, status_d;
  word_type rdata_q, rdata_d;
  logic taken_q, taken_d;
  class_type class_q, class_d;
  mode_type mode, new_mode;
  logic can_return;

  exc_if ex ();

  assign mode = status_q[MODE_LSB +: 5];
  assign can_return = exc_return && has_saved(mode);
  assign ex.req = exc_req;
  assign ex.fast_off = status_q[FAST_OFF_BIT];
  assign ex.irq_off = status_q[IRQ_OFF_BIT];
  assign new_mode = exc_mode(ex.cls);

  exc_arbiter exc_arbiter_inst (
    .ex(ex.arb)
  );

  cond_check cond_check_inst (
    .cond(instr[COND_LSB +: 4]),
    .flags(status_q[FLAG_LSB +: 4]),
    .pass(cond_pass)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    regs_d = regs_q;
    saved_d = saved_q;
    status_d = status_q;
    rdata_d = rdata_q;
    taken_d = 1'b0;
    class_d = class_q;
    if (reg_rd) begin
      // see RQ1, see RQ2, see RQ16
      rdata_d = regs_q[phys_index(mode, reg_addr)];
    end
    if (ex.grant) begin
      // see RQ10, see RQ11, see RQ7
      regs_d[phys_index(new_mode, IDX_LINK)] = ret_addr; // see RQ4, see RQ3
      saved_d[saved_slot(new_mode)] = status_q; // see RQ9
      status_d[MODE_LSB +: 5] = new_mode;
      status_d[IRQ_OFF_BIT] = 1'b1;
      status_d[STATE_BIT] = 1'b0;
      if (ex.cls == CLS_FAST) begin
        status_d[FAST_OFF_BIT] = 1'b1;
      end
      regs_d[PC_SLOT] = VEC_BASE + {27'h0000000, ex.cls, 2'b00};
      taken_d = 1'b1;
      class_d = ex.cls;
    end else if (can_return) begin
      // see RQ12
      status_d = saved_q[saved_slot(mode)];
      regs_d[PC_SLOT] = regs_q[phys_index(mode, IDX_LINK)];
    end else begin
      if (reg_wr) begin
        // see RQ2, see RQ5, see RQ6, see RQ15
        regs_d[phys_index(mode, reg_addr)] = reg_wdata;
      end
      if (status_wr && mode != MODE_USR) begin
        status_d = status_wdata & STATUS_MASK; // see RQ8
      end else if (flags_wr) begin
        status_d[FLAG_LSB +: 4] = flags_in; // see RQ8
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NUM_PHYS; k++) begin
        regs_q[k] <= 32'h00000000;
      end
      for (int k = 0; k < NUM_SAVED; k++) begin
        saved_q[k] <= 32'h00000000;
      end
      status_q <= STATUS_RST;
      rdata_q <= 32'h00000000;
      taken_q <= 1'b0;
      class_q <= 3'h0;
    end else begin
      regs_q <= regs_d;
      saved_q <= saved_d;
      status_q <= status_d;
      rdata_q <= rdata_d;
      taken_q <= taken_d;
      class_q <= class_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign exc_taken = taken_q;
  assign exc_class = class_q;
  assign status_word = status_q;
  assign pc = regs_q[PC_SLOT];
  assign cur_mode = mode;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  entry_link_a: assert property ( // see RQ4
    ex.grant |=> regs_q[phys_index(mode, IDX_LINK)] == $past(ret_addr))
    else $error("link register not loaded on entry");

  saved_status_a: assert property ( // see RQ9
    ex.grant |=> saved_q[saved_slot(mode)] == $past(status_q) && exc_taken)
    else $error("saved status wrong on entry");

  entry_mode_a: assert property ( // see RQ10
    ex.grant |=> mode == exc_mode(exc_class) && status_q[IRQ_OFF_BIT])
    else $error("wrong mode after entry");

  return_restore_a: assert property ( // see RQ12
    !ex.grant && can_return
      |=> status_q == $past(saved_q[saved_slot(mode)])
      && pc == $past(regs_q[phys_index(mode, IDX_LINK)]))
    else $error("return did not restore state");

  shared_low_a: assert property ( // see RQ1
    reg_wr && reg_addr < 4'h8 && !ex.grant && !can_return
      |=> regs_q[$past(reg_addr)] == $past(reg_wdata))
    else $error("low register not shared");

  fast_bank_a: assert property ( // see RQ6
    reg_wr && mode == MODE_FAST && reg_addr >= 4'h8 && reg_addr <= 4'hC
      && !ex.grant && !can_return
      |=> regs_q[$past(reg_addr)] == $past(regs_q[reg_addr]))
    else $error("fast mode wrote user bank");

  sys_unbanked_a: assert property ( // see RQ7
    reg_wr && mode == MODE_SYS && reg_addr >= 4'h8 && reg_addr < IDX_PC
      && !ex.grant |=> regs_q[$past(reg_addr)] == $past(reg_wdata))
    else $error("system mode not using user registers");

  read_latency_a: assert property ( // see RQ2
    reg_rd |=> reg_rdata == $past(regs_q[phys_index(mode, reg_addr)]))
    else $error("read data wrong or late");

  pick_order_a: assert property ( // see RQ17
    exc_req[CLS_ABT] |=> exc_taken && exc_class == CLS_ABT)
    else $error("abort not taken first");

  cond_always_a: assert property ( // see RQ14
    instr[COND_LSB +: 4] == COND_AL |-> cond_pass)
    else $error("always condition failed");

  // ----------------------------------------
  // bank and entry checks
  // ----------------------------------------
  private_stack_a: assert property ( // see RQ5
    reg_wr && has_saved(mode) && reg_addr == IDX_SP
      && !ex.grant && !can_return
      |=> regs_q[IDX_SP] == $past(regs_q[IDX_SP]))
    else $error("user stack pointer overwritten");

  private_link_a: assert property ( // see RQ3
    reg_wr && has_saved(mode) && reg_addr == IDX_LINK
      && !ex.grant && !can_return
      |=> regs_q[IDX_LINK] == $past(regs_q[IDX_LINK]))
    else $error("user link register overwritten");

  low_read_a: assert property ( // see RQ1
    reg_rd && reg_addr < 4'h8
      |=> reg_rdata == $past(regs_q[reg_addr]))
    else $error("low register read not shared");

  fast_read_a: assert property ( // see RQ6
    reg_rd && mode == MODE_FAST && reg_addr >= 4'h8 && reg_addr <= 4'hC
      |=> reg_rdata == $past(regs_q[FAST_LOW_SLOT + 5'(reg_addr) - 5'h08]))
    else $error("fast mode read wrong bank");

  pc_read_a: assert property ( // see RQ16
    reg_rd && reg_addr == IDX_PC
      |=> reg_rdata == $past(pc))
    else $error("index 15 does not read the pc");

  pc_hold_a: assert property ( // see RQ16
    !ex.grant && !can_return
      && !(reg_wr && reg_addr == IDX_PC)
      |=> pc == $past(pc))
    else $error("pc moved without a cause");

  rdata_hold_a: assert property ( // see RQ2
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  fast_mask_a: assert property ( // see RQ10
    ex.grant && ex.cls == CLS_FAST
      |=> status_q[FAST_OFF_BIT] && mode == MODE_FAST)
    else $error("fast entry left fast requests open");

  fast_keep_a: assert property ( // see RQ10
    ex.grant && ex.cls != CLS_FAST
      |=> status_q[FAST_OFF_BIT] == $past(status_q[FAST_OFF_BIT]))
    else $error("fast mask changed by slower entry");

  entry_state_a: assert property ( // see RQ8
    ex.grant |=> !status_q[STATE_BIT]
      && status_q[FLAG_LSB +: 4] == $past(status_q[FLAG_LSB +: 4]))
    else $error("entry disturbed state bit or flags");

  entry_vector_a: assert property ( // see RQ17
    ex.grant
      |=> pc == VEC_BASE + 32'($past(ex.cls)) * 32'h00000004)
    else $error("entry pc not at class vector");

  entry_user_link_a: assert property ( // see RQ3
    ex.grant && !has_saved(mode)
      |=> regs_q[IDX_LINK] == $past(regs_q[IDX_LINK]))
    else $error("entry overwrote the user link register");

  taken_pulse_a: assert property ( // see RQ10
    !ex.grant |=> !exc_taken)
    else $error("exception taken without a grant");

  class_hold_a: assert property ( // see RQ10
    !ex.grant |=> $stable(exc_class))
    else $error("class changed without a grant");

  user_lock_a: assert property ( // see RQ8
    mode == MODE_USR && !ex.grant && !can_return
      |=> mode == MODE_USR)
    else $error("user mode left without an exception");

  status_mask_a: assert property ( // see RQ8
    (status_q & ~STATUS_MASK) == 32'h00000000)
    else $error("reserved status bits set");

  cond_never_a: assert property ( // see RQ14
    instr[COND_LSB +: 4] == 4'hF |-> !cond_pass)
    else $error("never condition passed");

  for (genvar s = 0; s < NUM_SAVED; s++) begin : g_saved_chk
    saved_hold_a: assert property ( // see RQ9
      !ex.grant |=> saved_q[s] == $past(saved_q[s]))
      else $error("saved status changed without entry");
  end

endmodule

// >>> verif/exc_source.sv
// file: model of the exception sources facing the core
// assumes: one core clock; exc_taken and exc_class come from the core
`timescale 1ns/1ps
module exc_source (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // from the bench
  input wire logic [4:0] fire,
  // from the core
  input wire logic exc_taken,
  input wire regbank_pkg::class_type exc_class,
  // to the core
  output logic [4:0] exc_req
);
  import regbank_pkg::*;
  logic [4:0] pend_q;
  logic [4:0] pend_d;
  logic [4:0] done;
  // ----------------------------------------
  // requests stay up until served
  // ----------------------------------------
  always_comb begin
    done = exc_taken ? (5'h01 << exc_class) : 5'h00;
    exc_req = pend_q & ~done;
    pend_d = (pend_q & ~done) | fire;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 5'h00;
    end else begin
      pend_q <= pend_d;
    end
  end
endmodule

// >>> verif/banked_register_file_exception_state_bench.sv
// file: self-checking bench for the banked register file
// assumes: exception sources come from the exc_source model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module banked_register_file_exception_state_bench;
  import regbank_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  index_type reg_addr = 4'h0;
  word_type reg_wdata = 32'h0;
  word_type status_wdata = 32'h0;
  word_type ret_addr = 32'h0;
  word_type instr = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic flags_wr = 1'b0;
  logic status_wr = 1'b0;
  logic exc_return = 1'b0;
  logic [3:0] flags_in = 4'h0;
  logic [4:0] fire = 5'h00;
  logic [4:0] exc_req;
  logic exc_taken;
  logic cond_pass;
  class_type exc_class;
  word_type reg_rdata;
  word_type status_word;
  word_type pc;
  mode_type cur_mode;
  int miscompares = 0;
  int n_tests = 0;
  mode_type mtab[6] = '{MODE_SUPER, MODE_ABT, MODE_UND, MODE_IRQ, MODE_SYS, MODE_FAST};
  mode_type ctab[5] = '{MODE_ABT, MODE_FAST, MODE_IRQ, MODE_UND, MODE_SUPER};

  always #50 sys_clk = ~sys_clk;

  regbank_core regbank_core_inst (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flags_wr(flags_wr), .flags_in(flags_in), .status_wr(status_wr),
    .status_wdata(status_wdata), .exc_req(exc_req), .ret_addr(ret_addr),
    .exc_return(exc_return), .exc_taken(exc_taken), .exc_class(exc_class),
    .instr(instr), .cond_pass(cond_pass), .status_word(status_word), .pc(pc),
    .cur_mode(cur_mode));
  exc_source exc_source_inst (.sys_clk(sys_clk), .nrst(nrst), .fire(fire),
    .exc_taken(exc_taken), .exc_class(exc_class), .exc_req(exc_req));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input index_type a, input word_type d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input index_type a, input word_type e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic set_mode(input mode_type m);
    @(posedge sys_clk);
    status_wdata <= {27'h0, m};
    status_wr <= 1'b1;
    @(posedge sys_clk);
    status_wr <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic take(input logic [4:0] m, input word_type a);
    @(posedge sys_clk);
    ret_addr <= a;
    fire <= m;
    @(posedge sys_clk);
    fire <= 5'h00;
  endtask
  task automatic wait_taken(input int k, input word_type s);
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge sys_clk);
      if (exc_taken === 1'b1) break;
    end
    if (exc_taken !== 1'b1) begin
      miscompares++;
      stop_test();
    end else begin
      `CHK("exc_class", k[2:0], exc_class)
      `CHK("cur_mode", ctab[k], cur_mode)
      `CHK("pc", VEC_BASE + 32'(k * 4), pc)
      `CHK("status_word", s, status_word)
    end
  endtask
  task automatic do_return(input word_type s, input word_type p);
    @(posedge sys_clk);
    exc_return <= 1'b1;
    @(posedge sys_clk);
    exc_return <= 1'b0;
    @(negedge sys_clk);
    `CHK("status_word", s, status_word)
    `CHK("pc", p, pc)
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_banks();
    int j;
    wr(4'h0, 32'h11);
    wr(4'h8, 32'h88);
    for (j = 0; j < 6; j++) begin
      set_mode(mtab[j]);
      `CHK("cur_mode", mtab[j], cur_mode)
      wr(IDX_SP, 32'hD0 + 32'(j));
      wr(IDX_LINK, 32'hE0 + 32'(j));
    end
    for (j = 0; j < 6; j++) begin
      set_mode(mtab[j]);
      rd(IDX_SP, 32'hD0 + 32'(j));
      rd(IDX_LINK, 32'hE0 + 32'(j));
      rd(4'h0, 32'h11);
    end
    wr(4'h8, 32'hF8);
    rd(4'h8, 32'hF8);
    set_mode(MODE_USR);
    rd(4'h8, 32'h88);
    rd(IDX_SP, 32'hD4);
    @(posedge sys_clk);
    flags_in <= 4'hA;
    flags_wr <= 1'b1;
    @(posedge sys_clk);
    flags_wr <= 1'b0;
    set_mode(MODE_SUPER);
    `CHK("cur_mode", MODE_USR, cur_mode)
    `CHK("status_word", 32'hA0000010, status_word)
    $display("test banks done");
  endtask
  task automatic t_classes();
    int k;
    for (k = 0; k < 5; k++) begin
      take(5'h01 << k, 32'h1000 + 32'(k));
      wait_taken(k, 32'hA0000080 | ((k == 1) ? 32'h40 : 32'h0) | {27'h0, ctab[k]});
      rd(IDX_LINK, 32'h1000 + 32'(k));
      rd(IDX_PC, VEC_BASE + 32'(k * 4));
      do_return(32'hA0000010, 32'h1000 + 32'(k));
    end
    $display("test classes done");
  endtask
  task automatic t_coincide();
    take(5'h11, 32'h2000);
    wait_taken(0, 32'hA0000094);
    wait_taken(4, 32'hA0000093);
    do_return(32'hA0000094, 32'h2000);
    do_return(32'hA0000010, 32'h2000);
    $display("test coincide done");
  endtask
  task automatic t_cond();
    logic [15:0] exp_pass;
    int c;
    exp_pass = 16'h6996;
    for (c = 0; c < 16; c++) begin
      @(posedge sys_clk);
      instr <= {c[3:0], 28'h0000000};
      @(negedge sys_clk);
      `CHK("cond_pass", exp_pass[c], cond_pass)
    end
    $display("test cond done");
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    `CHK("status_word", STATUS_RST, status_word)
    `CHK("pc", 32'h0, pc)
    `CHK("exc_taken", 1'b0, exc_taken)
    t_banks();
    t_classes();
    t_coincide();
    t_cond();
    stop_test();
  end
endmodule
